// [tmr_chan_pkg.sv]
// Package for the two-channel timer per-channel control block.
// Holds register layouts, reset values, pin function codes and carrier structs.
package tmr_chan_pkg;

    localparam int N_CH = 2;

    // Register select codes on the 8-bit register path.
    localparam logic [3:0] SEL_IRQ_EN   = 4'h0;
    localparam logic [3:0] SEL_OUT_LVL  = 4'h1;
    localparam logic [3:0] SEL_FILTER   = 4'h2;
    localparam logic [3:0] SEL_MODE_A   = 4'h3;

    // Interrupt enable register fields.
    localparam int IE_OVF   = 4;
    localparam int IE_D     = 3;
    localparam int IE_C     = 2;
    localparam int IE_B     = 1;
    localparam int IE_A     = 0;
    localparam logic [7:0] IE_RSVD_ONES  = 8'hE0;
    localparam logic [7:0] IE_WMASK      = 8'h1F;
    localparam logic [7:0] IE_RESET      = 8'h00;

    // Output level register fields.
    localparam int LVL_D    = 2;
    localparam int LVL_C    = 1;
    localparam int LVL_B    = 0;
    localparam logic [7:0] LVL_RSVD_ONES = 8'hF8;
    localparam logic [7:0] LVL_WMASK     = 8'h07;
    localparam logic [7:0] LVL_RESET     = 8'h00;

    // Filter select register fields.
    localparam int FLT_CK_HI = 7;
    localparam int FLT_CK_LO = 6;
    localparam logic [7:0] FLT_WMASK     = 8'hCF;
    localparam logic [7:0] FLT_RESET     = 8'h00;

    // Filter sampling clock choices.
    localparam logic [1:0] FCK_DIV32 = 2'b00;
    localparam logic [1:0] FCK_DIV8  = 2'b01;
    localparam logic [1:0] FCK_PHI   = 2'b10;
    localparam logic [1:0] FCK_PRESC = 2'b11;
    localparam logic [4:0] DIV32_LAST = 5'h1F;
    localparam logic [4:0] DIV8_MASK  = 5'h07;

    // Filter agreement length in samples.
    localparam logic [1:0] FLT_SAMPLES = 2'h3;

    // Combination field codes.
    localparam logic [1:0] CMB_NONE = 2'b00;
    localparam logic [1:0] CMB_RSYN = 2'b01;

    // Pin A of channel 0 function, one-hot.
    typedef enum logic [3:0] {
        PIN_GPIO    = 4'b0001,
        PIN_PWM_MODE_THREE    = 4'b0010,
        PIN_COMPARE = 4'b0100,
        PIN_CAPTURE = 4'b1000
    } pin_func_t;

    // Status flags of one channel.
    typedef struct packed {
        logic overflow_flag;
        logic underflow_flag;
        logic match_flag_d;
        logic match_flag_c;
        logic match_flag_b;
        logic match_flag_a;
    } chan_flags_t;

    // Interrupt requests of one channel.
    typedef struct packed {
        logic overflow_irq;
        logic match_irq_d;
        logic match_irq_c;
        logic match_irq_b;
        logic match_irq_a;
    } chan_irq_t;

    // Mode bits that select pin A of channel 0.
    typedef struct packed {
        logic       pin_a_ch0_output_disable;
        logic       external_clock_start;
        logic [1:0] combination_mode_field;
        logic       pwm_mode_three;
        logic [2:0] pin_a_io_select;
    } pin_a_mode_t;

endpackage

// [tmr_pin_filter.sv]
// Digital noise filter for one capture pin.
// Assumes the pin is already synchronous to clk; sample_en is a one-cycle strobe.
`timescale 1ns/1ps
module tmr_pin_filter (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic sample_en,
    input  wire logic bypass,
    // Pin
    input  wire logic pin_in,
    output logic      pin_out
);

    logic [1:0] agree_q;
    logic       level_q;
    logic       prev_q;

    // The level only moves after the pin holds steady for a full run of samples.
    always_ff @(posedge clk) begin
        if (rst) begin
            agree_q <= 2'h0;
            level_q <= 1'b0;
            prev_q  <= 1'b0;
        end else if (sample_en) begin
            prev_q <= pin_in;
            if (pin_in != prev_q) begin
                agree_q <= 2'h0;
            end else if (agree_q != tmr_chan_pkg::FLT_SAMPLES) begin
                agree_q <= agree_q + 2'h1;
            end else begin
                level_q <= pin_in;
            end
        end
    end

    assign pin_out = bypass ? pin_in : level_q;

endmodule

// [tmr_chan_ctrl.sv]
// Per-channel interrupt gating, PWM level control, input filters and pin A mode decode.
// Assumes the CPU drives an 8-bit register path synchronous to clk; the counting engine
// supplies flags, the prescaler clock strobe and raw PWM levels.
//
// Summary of operation
// - Enable bit 4 gates overflow and underflow flags onto the overflow request.
// - Enable bit 3 gates match flag D onto its request.
// - Enable bit 2 gates match flag C onto its request.
// - Enable bit 1 gates match flag B onto its request.
// - Enable bit 0 gates match flag A onto its request.
// - Unused enable bits 7-5 and level bits 7-3 read one; all reset zero.
// - Each of two channels has its own enable, level and filter registers.
// - In PWM mode level bit 2 picks pin D active level.
// - In PWM mode level bit 1 picks pin C active level.
// - In PWM mode level bit 0 picks pin B active level.
// - Filter bits 7:6 pick phi/32, phi/8, phi or the prescaler clock.
// - Filter bits 3..0 enable the filter on pins D, C, B, A.
// - A filter setting acts only while its pin is an input.
// - Filter bits 5 and 4 read zero.
// - Counter and compare registers are whole 16-bit words, never bytes.
// - All other registers sit on an 8-bit path.
// - Register settings choose timer, PWM, PWM_MODE_THREE and combination modes.
// - Channel 0 pin A gives PWM_MODE_THREE output with all select bits clear.
// - Channel 0 pin A is compare output for PWM_MODE_THREE bit one, I/O 001 or 01X.
// - Channel 0 pin A captures for I/O 1XX with PWM_MODE_THREE bit one, else general I/O.
// - Combination field 01 is reset synchronous, 10 or 11 complementary.
`timescale 1ns/1ps
module tmr_chan_ctrl (
    // Clock and reset
    input  wire logic                                             clk,
    input  wire logic                                             rst,
    // 8-bit register path
    input  wire logic                                             reg_sel_ch,
    input  wire logic [3:0]                                       reg_sel,
    input  wire logic                                             reg_wr,
    input  wire logic                                             reg_rd,
    input  wire logic [7:0]                                       reg_wdata,
    output logic      [7:0]                                       reg_rdata,
    // Flags from the counting engine
    input  wire tmr_chan_pkg::chan_flags_t [tmr_chan_pkg::N_CH-1:0] flags,
    output tmr_chan_pkg::chan_irq_t [tmr_chan_pkg::N_CH-1:0]      irq,
    // Mode state from the timer's mode registers
    input  wire logic [tmr_chan_pkg::N_CH-1:0][2:0]               pwm_mode_pins,
    input  wire logic [tmr_chan_pkg::N_CH-1:0][3:0]               pin_is_input,
    input  wire logic                                             presc_tick,
    // PWM waveform levels and pins
    input  wire logic [tmr_chan_pkg::N_CH-1:0][2:0]               pwm_raw,
    output logic      [tmr_chan_pkg::N_CH-1:0][2:0]               pwm_pin_out,
    // Capture pins and filtered result
    input  wire logic [tmr_chan_pkg::N_CH-1:0][3:0]               cap_pin_in,
    output logic      [tmr_chan_pkg::N_CH-1:0][3:0]               cap_filtered,
    // Channel 0 pin A function
    output tmr_chan_pkg::pin_func_t                               pin_a0_func,
    output logic                                                  complementary_mode,
    output logic                                                  reset_sync_mode
);

    logic [tmr_chan_pkg::N_CH-1:0][7:0] irq_en_q;
    logic [tmr_chan_pkg::N_CH-1:0][7:0] out_lvl_q;
    logic [tmr_chan_pkg::N_CH-1:0][7:0] filter_q;
    tmr_chan_pkg::pin_a_mode_t          mode_a_q;
    logic [4:0]                         div_q;
    logic [tmr_chan_pkg::N_CH-1:0]      tick;
    logic [tmr_chan_pkg::N_CH-1:0][3:0] filt_raw;
    logic [7:0]                         rdata_d;

    // Write strobe decode used by every register.
    function automatic logic hit(input logic [3:0] sel, input logic ch_sel,
                                 input logic [3:0] want, input int ch);
        hit = (sel == want) && (ch_sel == ch[0]);
    endfunction

    // Free divider for the phi/8 and phi/32 filter sampling strobes.
    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= 5'h00;
        end else begin
            div_q <= div_q + 5'h01;
        end
    end

    // Mode bits of pin A, channel 0, loaded as one byte on the 8-bit path.
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_a_q <= '0;
        end else if (reg_wr && hit(reg_sel, reg_sel_ch, tmr_chan_pkg::SEL_MODE_A, 0)) begin
            mode_a_q <= reg_wdata;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < tmr_chan_pkg::N_CH; ch++) begin : g_ch
            // Separate register set for every channel.
            always_ff @(posedge clk) begin
                if (rst) begin
                    irq_en_q[ch]  <= tmr_chan_pkg::IE_RESET;
                    out_lvl_q[ch] <= tmr_chan_pkg::LVL_RESET;
                    filter_q[ch]  <= tmr_chan_pkg::FLT_RESET;
                end else if (reg_wr) begin
                    if (hit(reg_sel, reg_sel_ch, tmr_chan_pkg::SEL_IRQ_EN, ch)) begin
                        irq_en_q[ch] <= reg_wdata & tmr_chan_pkg::IE_WMASK;
                    end else if (hit(reg_sel, reg_sel_ch, tmr_chan_pkg::SEL_OUT_LVL, ch)) begin
                        out_lvl_q[ch] <= reg_wdata & tmr_chan_pkg::LVL_WMASK;
                    end else if (hit(reg_sel, reg_sel_ch, tmr_chan_pkg::SEL_FILTER, ch)) begin
                        filter_q[ch] <= reg_wdata & tmr_chan_pkg::FLT_WMASK;
                    end
                end
            end

            // Requests follow flag AND enable with one register stage.
            always_ff @(posedge clk) begin
                if (rst) begin
                    irq[ch] <= '0;
                end else begin
                    irq[ch].overflow_irq <= (flags[ch].overflow_flag
                        | flags[ch].underflow_flag) & irq_en_q[ch][tmr_chan_pkg::IE_OVF];
                    irq[ch].match_irq_d <= flags[ch].match_flag_d
                        & irq_en_q[ch][tmr_chan_pkg::IE_D];
                    irq[ch].match_irq_c <= flags[ch].match_flag_c
                        & irq_en_q[ch][tmr_chan_pkg::IE_C];
                    irq[ch].match_irq_b <= flags[ch].match_flag_b
                        & irq_en_q[ch][tmr_chan_pkg::IE_B];
                    irq[ch].match_irq_a <= flags[ch].match_flag_a
                        & irq_en_q[ch][tmr_chan_pkg::IE_A];
                end
            end

            // A level bit of 0 inverts the raw high-true waveform, making the pin low-active.
            always_ff @(posedge clk) begin
                if (rst) begin
                    pwm_pin_out[ch] <= 3'h0;
                end else begin
                    pwm_pin_out[ch][2] <= pwm_mode_pins[ch][2]
                        ? ~(pwm_raw[ch][2] ^ out_lvl_q[ch][tmr_chan_pkg::LVL_D])
                        : pwm_raw[ch][2];
                    pwm_pin_out[ch][1] <= pwm_mode_pins[ch][1]
                        ? ~(pwm_raw[ch][1] ^ out_lvl_q[ch][tmr_chan_pkg::LVL_C])
                        : pwm_raw[ch][1];
                    pwm_pin_out[ch][0] <= pwm_mode_pins[ch][0]
                        ? ~(pwm_raw[ch][0] ^ out_lvl_q[ch][tmr_chan_pkg::LVL_B])
                        : pwm_raw[ch][0];
                end
            end

            // Sampling strobe chosen by the clock field.
            always_comb begin
                case (filter_q[ch][tmr_chan_pkg::FLT_CK_HI:tmr_chan_pkg::FLT_CK_LO])
                    tmr_chan_pkg::FCK_DIV32: tick[ch] = (div_q == tmr_chan_pkg::DIV32_LAST);
                    tmr_chan_pkg::FCK_DIV8:
                        tick[ch] = ((div_q & tmr_chan_pkg::DIV8_MASK)
                                    == tmr_chan_pkg::DIV8_MASK);
                    tmr_chan_pkg::FCK_PHI:   tick[ch] = 1'b1;
                    default:                 tick[ch] = presc_tick;
                endcase
            end

            genvar p;
            for (p = 0; p < 4; p++) begin : g_pin
                // Bit p enables the filter of pin p (A at 0 .. D at 3), only for inputs.
                tmr_pin_filter tmr_pin_filter_i (
                    .clk       (clk),
                    .rst       (rst),
                    .sample_en (tick[ch]),
                    .bypass    (~(filter_q[ch][p] & pin_is_input[ch][p])),
                    .pin_in    (cap_pin_in[ch][p]),
                    .pin_out   (filt_raw[ch][p])
                );
            end

            always_ff @(posedge clk) begin
                if (rst) begin
                    cap_filtered[ch] <= 4'h0;
                end else begin
                    cap_filtered[ch] <= filt_raw[ch];
                end
            end
        end
    endgenerate

    // Pin A of channel 0 function decode.
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_a0_func        <= tmr_chan_pkg::PIN_GPIO;
            complementary_mode <= 1'b0;
            reset_sync_mode    <= 1'b0;
        end else begin
            complementary_mode <= mode_a_q.combination_mode_field[1];
            reset_sync_mode    <= (mode_a_q.combination_mode_field
                                   == tmr_chan_pkg::CMB_RSYN);
            if (mode_a_q.pin_a_ch0_output_disable) begin
                pin_a0_func <= tmr_chan_pkg::PIN_GPIO;
            end else if (!mode_a_q.external_clock_start
                         && mode_a_q.combination_mode_field == tmr_chan_pkg::CMB_NONE
                         && !mode_a_q.pwm_mode_three) begin
                pin_a0_func <= tmr_chan_pkg::PIN_PWM_MODE_THREE;
            end else if (mode_a_q.combination_mode_field == tmr_chan_pkg::CMB_NONE
                         && mode_a_q.pwm_mode_three
                         && (mode_a_q.pin_a_io_select == 3'b001
                             || mode_a_q.pin_a_io_select[2:1] == 2'b01)) begin
                pin_a0_func <= tmr_chan_pkg::PIN_COMPARE;
            end else if (mode_a_q.pwm_mode_three && mode_a_q.pin_a_io_select[2]) begin
                pin_a0_func <= tmr_chan_pkg::PIN_CAPTURE;
            end else begin
                pin_a0_func <= tmr_chan_pkg::PIN_GPIO;
            end
        end
    end

    // Read data; reserved ones are forced on the fly.
    always_comb begin
        // Only byte registers live here; the word-wide counter and compare registers do not.
        rdata_d = 8'h00;
        if (reg_sel == tmr_chan_pkg::SEL_IRQ_EN) begin
            rdata_d = irq_en_q[reg_sel_ch] | tmr_chan_pkg::IE_RSVD_ONES;
        end else if (reg_sel == tmr_chan_pkg::SEL_OUT_LVL) begin
            rdata_d = out_lvl_q[reg_sel_ch] | tmr_chan_pkg::LVL_RSVD_ONES;
        end else if (reg_sel == tmr_chan_pkg::SEL_FILTER) begin
            rdata_d = filter_q[reg_sel_ch] & tmr_chan_pkg::FLT_WMASK;
        end else if (reg_sel == tmr_chan_pkg::SEL_MODE_A && !reg_sel_ch) begin
            rdata_d = mode_a_q;
        end
    end

    // Read data is registered: it appears one cycle after the read strobe.
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end
    end

endmodule

// [tmr_chan_ctrl_assertions.sv]
// Checker for the per-channel control block, bound to its top module.
// Assumes one clock domain; channel 0 enable and level bytes are shadowed from the writes.
`timescale 1ns/1ps
module tmr_chan_ctrl_checker (
    // Clock and reset
    input wire logic                                               clk,
    input wire logic                                               rst,
    // Register path
    input wire logic                                               reg_sel_ch,
    input wire logic [3:0]                                         reg_sel,
    input wire logic                                               reg_wr,
    input wire logic                                               reg_rd,
    input wire logic [7:0]                                         reg_wdata,
    input wire logic [7:0]                                         reg_rdata,
    // Requests and PWM levels
    input wire tmr_chan_pkg::chan_flags_t [tmr_chan_pkg::N_CH-1:0] flags,
    input wire tmr_chan_pkg::chan_irq_t [tmr_chan_pkg::N_CH-1:0]   irq,
    input wire logic [tmr_chan_pkg::N_CH-1:0][2:0]                 pwm_mode_pins,
    input wire logic [tmr_chan_pkg::N_CH-1:0][2:0]                 pwm_raw,
    input wire logic [tmr_chan_pkg::N_CH-1:0][2:0]                 pwm_pin_out
);
    logic [4:0] ie_q;
    logic [2:0] lvl_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    always_ff @(posedge clk) begin
        if (rst) begin
            ie_q <= 5'h00;
        end else if (reg_wr && !reg_sel_ch && reg_sel == tmr_chan_pkg::SEL_IRQ_EN) begin
            ie_q <= reg_wdata[4:0];
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            lvl_q <= 3'h0;
        end else if (reg_wr && !reg_sel_ch && reg_sel == tmr_chan_pkg::SEL_OUT_LVL) begin
            lvl_q <= reg_wdata[2:0];
        end
    end
    a_ovf_irq_gate: assert property (irq[0].overflow_irq ==
        $past((flags[0].overflow_flag | flags[0].underflow_flag) & ie_q[4]))
        else $error("overflow request does not follow its gate");
    a_match_d_gate: assert property (irq[0].match_irq_d ==
        $past(flags[0].match_flag_d & ie_q[3])) else $error("request d wrong");
    a_match_c_gate: assert property (flags[0].match_flag_c && ie_q[2]
        |=> irq[0].match_irq_c) else $error("request c missing");
    a_match_b_off: assert property (!ie_q[1] |=> !irq[0].match_irq_b)
        else $error("request b while disabled");
    a_match_a_cause: assert property ($rose(irq[0].match_irq_a)
        |-> $past(flags[0].match_flag_a && ie_q[0])) else $error("request a uncaused");
    a_ie_reads_ones: assert property (reg_rd && reg_sel == tmr_chan_pkg::SEL_IRQ_EN
        |=> reg_rdata[7:5] == 3'h7) else $error("enable reserved bits not one");
    a_lvl_reads_ones: assert property (reg_rd && reg_sel == tmr_chan_pkg::SEL_OUT_LVL
        |=> reg_rdata[7:3] == 5'h1F) else $error("level reserved bits not one");
    a_flt_reads_zero: assert property (reg_rd && reg_sel == tmr_chan_pkg::SEL_FILTER
        |=> reg_rdata[5:4] == 2'h0) else $error("filter reserved bits not zero");
    a_pwm_level_b: assert property (pwm_mode_pins[0][0] |=> pwm_pin_out[0][0] ==
        ($past(pwm_raw[0][0]) ~^ $past(lvl_q[0]))) else $error("pin b level wrong");
endmodule
bind tmr_chan_ctrl tmr_chan_ctrl_checker tmr_chan_ctrl_checker_i (.clk, .rst, .reg_sel_ch,
    .reg_sel, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .flags, .irq, .pwm_mode_pins,
    .pwm_raw, .pwm_pin_out);

// [tmr_engine_model.sv]
// Stand-in for the counting engine: holds the status flags and makes the prescaler strobe.
// Assumes the bench pulses the set and clear vectors for one cycle at a time.
`timescale 1ns/1ps
module tmr_engine_model (
    // Clock and reset
    input  wire logic                                               clk,
    input  wire logic                                               rst,
    // Bench commands
    input  wire tmr_chan_pkg::chan_flags_t [tmr_chan_pkg::N_CH-1:0] set_f,
    input  wire tmr_chan_pkg::chan_flags_t [tmr_chan_pkg::N_CH-1:0] clr_f,
    // Towards the block
    output tmr_chan_pkg::chan_flags_t [tmr_chan_pkg::N_CH-1:0]      flags,
    output logic                                                    presc_tick
);
    logic [3:0] div_q;
    // Software clears only after seeing the flag set, so a clear never races a set here.
    always_ff @(posedge clk) begin
        if (rst) begin
            flags <= '0;
        end else begin
            flags <= (flags | set_f) & ~clr_f;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= 4'h0;
            presc_tick <= 1'b0;
        end else begin
            div_q <= div_q + 4'h1;
            presc_tick <= (div_q == 4'hF);
        end
    end
endmodule

// [tmr_chan_ctrl_tb.sv]
// Self-checking bench for the per-channel control block.
// Assumes the engine stand-in drives flags and the prescaler strobe.
`timescale 1ns/1ps
module tmr_chan_ctrl_tb;
    logic                                               clk, rst, reg_sel_ch, reg_wr, reg_rd;
    logic [3:0]                                         reg_sel;
    logic [7:0]                                         reg_wdata, reg_rdata;
    tmr_chan_pkg::chan_flags_t [tmr_chan_pkg::N_CH-1:0] flags, set_f, clr_f;
    tmr_chan_pkg::chan_irq_t [tmr_chan_pkg::N_CH-1:0]   irq;
    logic [tmr_chan_pkg::N_CH-1:0][2:0]                 pwm_mode_pins, pwm_raw, pwm_pin_out;
    logic [tmr_chan_pkg::N_CH-1:0][3:0]                 pin_is_input, cap_pin_in, cap_filtered;
    tmr_chan_pkg::pin_func_t                            pin_a0_func;
    logic                                               presc_tick, complementary_mode;
    logic                                               reset_sync_mode;
    int                                                 num_errors, total_checks;
    localparam logic [7:0] mode_in [12] = '{8'h00, 8'h09, 8'h0A, 8'h0B, 8'h4C, 8'h0F,
        8'h80, 8'h40, 8'h08, 8'h10, 8'h20, 8'h30};
    localparam logic [7:0] mode_ex [12] = '{8'h08, 8'h10, 8'h10, 8'h10, 8'h20, 8'h20,
        8'h04, 8'h04, 8'h04, 8'h05, 8'h06, 8'h06};
    localparam logic [7:0] rst_v [3] = '{8'hE0, 8'hF8, 8'h00};
    localparam logic [7:0] ful_v [3] = '{8'hFF, 8'hFF, 8'hCF};
    localparam int sht [4] = '{40, 12, 2, 40};
    localparam int lng [4] = '{200, 50, 10, 100};
    tmr_chan_ctrl tmr_chan_ctrl_i (.clk(clk), .rst(rst), .reg_sel_ch(reg_sel_ch),
        .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .flags(flags), .irq(irq), .pwm_mode_pins(pwm_mode_pins),
        .pin_is_input(pin_is_input), .presc_tick(presc_tick), .pwm_raw(pwm_raw),
        .pwm_pin_out(pwm_pin_out), .cap_pin_in(cap_pin_in), .cap_filtered(cap_filtered),
        .pin_a0_func(pin_a0_func), .complementary_mode(complementary_mode),
        .reset_sync_mode(reset_sync_mode));
    tmr_engine_model tmr_engine_model_i (.clk(clk), .rst(rst), .set_f(set_f),
        .clr_f(clr_f), .flags(flags), .presc_tick(presc_tick));
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input int ch, input logic [3:0] s, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_sel_ch = 1'(ch);
        reg_sel = s;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input int ch, input logic [3:0] s, input logic [7:0] e);
        @(posedge clk);
        #1;
        reg_sel_ch = 1'(ch);
        reg_sel = s;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        chk("read", e, reg_rdata);
    endtask
    task automatic fl(input int ch, input logic [5:0] s, input logic [5:0] c);
        @(posedge clk);
        #1;
        set_f[ch] = s;
        clr_f[ch] = c;
        cyc(1);
        set_f = '0;
        clr_f = '0;
        cyc(1);
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        $display("mismatch watchdog expected end seen hang");
        results();
    end
    initial begin
        {rst, reg_sel_ch, reg_wr, reg_rd, reg_sel, reg_wdata} = {4'h8, 12'h000};
        {set_f, clr_f, pwm_raw, cap_pin_in} = '0;
        pwm_mode_pins = '1;
        pin_is_input = '1;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        for (int c = 0; c < 2; c++) begin
            for (int r = 0; r < 3; r++) rd(c, 4'(r), rst_v[r]);
            for (int r = 0; r < 3; r++) wr(c, 4'(r), 8'hFF);
            for (int r = 0; r < 3; r++) rd(c, 4'(r), ful_v[r]);
        end
        wr(0, tmr_chan_pkg::SEL_IRQ_EN, 8'h00);
        rd(1, tmr_chan_pkg::SEL_IRQ_EN, 8'hFF);
        rd(0, 4'h5, 8'h00);
        $display("test registers done");
        for (int c = 0; c < 2; c++) begin
            for (int b = 0; b < 5; b++) begin
                wr(c, tmr_chan_pkg::SEL_IRQ_EN, 8'h01 << b);
                fl(c, 6'h3F, 6'h00);
                chk("irq", 8'h01 << b, {3'h0, irq[c]});
                fl(c, 6'h00, 6'h3F);
                chk("irq drop", 8'h00, {3'h0, irq[c]});
            end
            wr(c, tmr_chan_pkg::SEL_IRQ_EN, 8'h0F);
            fl(c, 6'h20, 6'h00);
            chk("irq off", 8'h00, {3'h0, irq[c]});
            wr(c, tmr_chan_pkg::SEL_IRQ_EN, 8'h10);
            fl(c, 6'h10, 6'h20);
            chk("irq under", 8'h10, {3'h0, irq[c]});
            fl(c, 6'h00, 6'h3F);
        end
        $display("test interrupts done");
        for (int c = 0; c < 2; c++) begin
            for (int v = 2; v < 6; v += 3) begin
                wr(c, tmr_chan_pkg::SEL_OUT_LVL, 8'(v));
                for (int r = 0; r < 8; r++) begin
                    pwm_raw[c] = 3'(r);
                    cyc(2);
                    chk("pwm", {5'h00, 3'(r) ^ ~3'(v)}, {5'h00, pwm_pin_out[c]});
                end
            end
            pwm_mode_pins[c] = 3'h0;
            cyc(2);
            chk("pwm off", 8'h07, {5'h00, pwm_pin_out[c]});
            pwm_mode_pins[c] = 3'h7;
        end
        $display("test pwm done");
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 4; k++) begin
                cap_pin_in[c] = 4'h0;
                wr(c, tmr_chan_pkg::SEL_FILTER, {2'(k), 6'h0F});
                cyc(lng[k]);
                cap_pin_in[c] = 4'hF;
                cyc(sht[k]);
                chk("flt hold", 8'h00, {4'h0, cap_filtered[c]});
                cyc(lng[k]);
                chk("flt pass", 8'h0F, {4'h0, cap_filtered[c]});
            end
            wr(c, tmr_chan_pkg::SEL_FILTER, 8'h00);
            cap_pin_in[c] = 4'h0;
            cyc(2);
            chk("flt bypass", 8'h00, {4'h0, cap_filtered[c]});
            wr(c, tmr_chan_pkg::SEL_FILTER, 8'h8F);
            pin_is_input[c] = 4'h0;
            // The filtered level still holds one here, so only a bypassed pin reads zero.
            cyc(2);
            chk("flt output pin", 8'h00, {4'h0, cap_filtered[c]});
            pin_is_input[c] = 4'hF;
        end
        $display("test filter done");
        for (int m = 0; m < 12; m++) begin
            wr(0, tmr_chan_pkg::SEL_MODE_A, mode_in[m]);
            cyc(3);
            chk("pin a", mode_ex[m], {2'h0, pin_a0_func, complementary_mode,
                reset_sync_mode});
        end
        wr(1, tmr_chan_pkg::SEL_MODE_A, 8'h09);
        cyc(3);
        chk("pin a ch1", 8'h06, {2'h0, pin_a0_func, complementary_mode, reset_sync_mode});
        $display("test pin modes done");
        results();
    end
endmodule
